// file: bst_test_port.v
`timescale 1ns/100ps
`include "bst_regs.vh"
// Overview of operation
// - four test pins only: data in, data out, mode select, test clock.
// - no test reset pin; reset only by walking the state machine.
// - data in sampled on rising test clock edge.
// - data out changes on falling test clock edge while shifting.
// - data out released whenever nothing is being shifted out.
// - mode select evaluated, state changed, only on rising test clock edge.
// - instruction register chooses operation and selected data register.
// - one-bit bypass register gives the shortest serial path.
// - data in feeds instruction register; its decode steers data registers.
// - boundary register is one chain from data in to data out.
// - every user pin adds a three-bit cell of capture and update stages.
// - every user pin, clock pins included, has its own cell; here only the N_IO pads have cells, clock and rst_n have none.
// - test pins and supplies have no cells.
// - capture stages sample core output data and enable.
// - update stages drive pad output value and enable.
// - cell captures out, enable, pad in; updates only out and enable.
// - shared shift, clock and update controls come from the controller.
// - functional or test data selection decoded from the instruction.
// - cell serial out chains to the next cell serial in.
// - standard sixteen-state controller on rising clock, steered by mode select.
// - instruction register is ten bits.
// - five clocks of mode select high forces reset state; stays there.
// - reset state disables scan, normal operation, loads identity instruction.
module bst_test_port #(
  parameter N_IO = 4,
  parameter [31:0] IDCODE = `BST_IDCODE_VAL // arbitrary value
) (
  input  wire            clock,
  input  wire            rst_n,
  input  wire            tck,
  input  wire            tms,
  input  wire            tdi,
  output reg             tdo_o,
  output reg             tdo_oe,
  input  wire [N_IO-1:0] core_output_data,
  input  wire [N_IO-1:0] core_output_enable,
  input  wire [N_IO-1:0] pad_in,
  output wire [N_IO-1:0] pad_out,
  output wire [N_IO-1:0] pad_oe,
  output reg             scan_active
);
  localparam IRL = `BST_IR_LEN;

  // one-hot tap states
  localparam [15:0] ST_RESET  = `BST_ST_RESET;
  localparam [15:0] ST_IDLE   = `BST_ST_IDLE;
  localparam [15:0] ST_SEL_DR = `BST_ST_SEL_DR;
  localparam [15:0] ST_CAP_DR = `BST_ST_CAP_DR;
  localparam [15:0] ST_SH_DR  = `BST_ST_SH_DR;
  localparam [15:0] ST_EX1_DR = `BST_ST_EX1_DR;
  localparam [15:0] ST_PA_DR  = `BST_ST_PA_DR;
  localparam [15:0] ST_EX2_DR = `BST_ST_EX2_DR;
  localparam [15:0] ST_UPD_DR = `BST_ST_UPD_DR;
  localparam [15:0] ST_SEL_IR = `BST_ST_SEL_IR;
  localparam [15:0] ST_CAP_IR = `BST_ST_CAP_IR;
  localparam [15:0] ST_SH_IR  = `BST_ST_SH_IR;
  localparam [15:0] ST_EX1_IR = `BST_ST_EX1_IR;
  localparam [15:0] ST_PA_IR  = `BST_ST_PA_IR;
  localparam [15:0] ST_EX2_IR = `BST_ST_EX2_IR;
  localparam [15:0] ST_UPD_IR = `BST_ST_UPD_IR;

  // two-flop synchronisers for pins from the tester's domain
  reg [1:0] tck_s_r;
  reg [1:0] tms_s_r;
  reg [1:0] tdi_s_r;
  reg       tck_d_r;
  always @(posedge clock) begin
    if (!rst_n) begin
      tck_s_r <= 2'h0;
      tms_s_r <= 2'h3;
      tdi_s_r <= 2'h3;
      tck_d_r <= 1'h0;
    end else begin
      tck_s_r <= {tck_s_r[0], tck};
      tms_s_r <= {tms_s_r[0], tms};
      tdi_s_r <= {tdi_s_r[0], tdi};
      tck_d_r <= tck_s_r[1];
    end
  end
  // each tck edge is seen three clocks late; tck high and low need three clocks each
  wire tck_rise = tck_s_r[1] & ~tck_d_r;
  wire tck_fall = ~tck_s_r[1] & tck_d_r;
  wire tms_v = tms_s_r[1];
  wire tdi_v = tdi_s_r[1];

  // pad levels are pins as well, so they get the same two flops
  reg [N_IO-1:0] pad_s1_r;
  reg [N_IO-1:0] pad_s2_r;
  always @(posedge clock) begin
    if (!rst_n) begin
      pad_s1_r <= {N_IO{1'h0}};
      pad_s2_r <= {N_IO{1'h0}};
    end else begin
      pad_s1_r <= pad_in;
      pad_s2_r <= pad_s1_r;
    end
  end

  // tap controller; rst_n is power-up only, no test reset pin
  reg [15:0] st_r;
  reg [15:0] st_nxt;
  always @* begin
    case (st_r)
      ST_RESET: begin
        st_nxt = tms_v ? ST_RESET : ST_IDLE;
      end
      ST_IDLE: begin
        st_nxt = tms_v ? ST_SEL_DR : ST_IDLE;
      end
      ST_SEL_DR: begin
        st_nxt = tms_v ? ST_SEL_IR : ST_CAP_DR;
      end
      ST_CAP_DR: begin
        st_nxt = tms_v ? ST_EX1_DR : ST_SH_DR;
      end
      ST_SH_DR: begin
        st_nxt = tms_v ? ST_EX1_DR : ST_SH_DR;
      end
      ST_EX1_DR: begin
        st_nxt = tms_v ? ST_UPD_DR : ST_PA_DR;
      end
      ST_PA_DR: begin
        st_nxt = tms_v ? ST_EX2_DR : ST_PA_DR;
      end
      ST_EX2_DR: begin
        st_nxt = tms_v ? ST_UPD_DR : ST_SH_DR;
      end
      ST_UPD_DR: begin
        st_nxt = tms_v ? ST_SEL_DR : ST_IDLE;
      end
      ST_SEL_IR: begin
        st_nxt = tms_v ? ST_RESET : ST_CAP_IR;
      end
      ST_CAP_IR: begin
        st_nxt = tms_v ? ST_EX1_IR : ST_SH_IR;
      end
      ST_SH_IR: begin
        st_nxt = tms_v ? ST_EX1_IR : ST_SH_IR;
      end
      ST_EX1_IR: begin
        st_nxt = tms_v ? ST_UPD_IR : ST_PA_IR;
      end
      ST_PA_IR: begin
        st_nxt = tms_v ? ST_EX2_IR : ST_PA_IR;
      end
      ST_EX2_IR: begin
        st_nxt = tms_v ? ST_UPD_IR : ST_SH_IR;
      end
      ST_UPD_IR: begin
        st_nxt = tms_v ? ST_SEL_DR : ST_IDLE;
      end
      default: begin
        st_nxt = ST_RESET;
      end
    endcase
  end
  always @(posedge clock) begin
    if (!rst_n) begin
      st_r <= ST_RESET;
    end else if (tck_rise) begin
      st_r <= st_nxt;
    end
  end

  wire in_reset  = st_r[0];
  wire cap_dr    = st_r[3];
  wire sh_dr     = st_r[4];
  wire upd_dr    = st_r[8];
  wire cap_ir    = st_r[10];
  wire sh_ir     = st_r[11];
  wire upd_ir    = st_r[15];

  // instruction register: shift stage and active stage
  reg [IRL-1:0] ir_sh_r;
  reg [IRL-1:0] ir_r;
  always @(posedge clock) begin
    if (!rst_n) begin
      ir_sh_r <= `BST_IR_RESET;
      ir_r    <= `BST_OP_IDCODE;
    end else if (tck_rise) begin
      if (cap_ir) begin
        ir_sh_r <= `BST_IR_RESET;
      end else if (sh_ir) begin
        ir_sh_r <= {tdi_v, ir_sh_r[IRL-1:1]};
      end
      if (in_reset) begin
        ir_r <= `BST_OP_IDCODE;
      end else if (upd_ir) begin
        ir_r <= ir_sh_r;
      end
    end
  end

  // decode; unknown codes fall back to bypass
  wire op_sample = (ir_r == `BST_OP_SAMPLE);
  wire op_extest = (ir_r == `BST_OP_EXTEST);
  wire op_idcode = (ir_r == `BST_OP_IDCODE);
  wire sel_bsr   = op_sample | op_extest;
  wire sel_id    = op_idcode;
  // clamp and highz would need extra pad control; both run as bypass here
  wire test_mode = op_extest & ~in_reset;

  // bypass register
  reg bypass_r;
  always @(posedge clock) begin
    if (!rst_n) begin
      bypass_r <= 1'h0;
    end else if (tck_rise) begin
      if (cap_dr) begin
        bypass_r <= 1'h0;
      end else if (sh_dr) begin
        bypass_r <= tdi_v;
      end
    end
  end

  // identity register
  reg [31:0] id_r;
  always @(posedge clock) begin
    if (!rst_n) begin
      id_r <= 32'h0000_0000;
    end else if (tck_rise && sel_id) begin
      if (cap_dr) begin
        id_r <= IDCODE;
      end else if (sh_dr) begin
        id_r <= {tdi_v, id_r[31:1]};
      end
    end
  end

  // global controls shared by every cell
  wire g_clk   = tck_rise & sel_bsr & (cap_dr | sh_dr);
  wire g_shift = sh_dr;
  wire g_upd   = tck_rise & sel_bsr & upd_dr;

  // boundary chain, tdi at the top cell, tdo from cell 0
  wire [N_IO:0] chain;
  assign chain[N_IO] = tdi_v;
  genvar gi;
  generate
    for (gi = 0; gi < N_IO; gi = gi + 1) begin : g_cell
      bst_scan_cell u_cell (
        .clock              (clock),
        .rst_n              (rst_n),
        .clk_en             (g_clk),
        .upd_en             (g_upd),
        .shift_sel          (g_shift),
        .test_mode          (test_mode),
        .cell_serial_in     (chain[gi+1]),
        .core_output_data   (core_output_data[gi]),
        .core_output_enable (core_output_enable[gi]),
        .pad_in             (pad_s2_r[gi]),
        .cell_serial_out    (chain[gi]),
        .pad_out            (pad_out[gi]),
        .pad_oe             (pad_oe[gi])
      );
    end
  endgenerate

  // serial output mux
  reg dr_bit;
  always @* begin
    if (sel_bsr) begin
      dr_bit = chain[0];
    end else if (sel_id) begin
      dr_bit = id_r[0];
    end else begin
      dr_bit = bypass_r;
    end
  end

  // released value is a plain 0 so no stale bit lingers on the pin
  reg tdo_nxt;
  reg tdo_oe_nxt;
  always @* begin
    tdo_oe_nxt = sh_ir | sh_dr;
    if (sh_ir) begin
      tdo_nxt = ir_sh_r[0];
    end else if (sh_dr) begin
      tdo_nxt = dr_bit;
    end else begin
      tdo_nxt = 1'h0;
    end
  end

  // tdo and its enable change only on falling tck
  always @(posedge clock) begin
    if (!rst_n) begin
      tdo_o       <= 1'h0;
      tdo_oe      <= 1'h0;
      scan_active <= 1'h0;
    end else begin
      scan_active <= test_mode;
      if (tck_fall) begin
        tdo_oe <= tdo_oe_nxt;
        tdo_o  <= tdo_nxt;
      end
    end
  end
endmodule

// file: bst_regs.vh
`ifndef BST_REGS_VH
`define BST_REGS_VH
`define BST_IR_LEN      10
`define BST_IR_RESET    10'h001
`define BST_OP_BYPASS   10'h3FF
`define BST_OP_SAMPLE   10'h005
`define BST_OP_EXTEST   10'h00F
`define BST_OP_IDCODE   10'h006
`define BST_OP_CLAMP    10'h00A
`define BST_OP_HIGHZ    10'h00B
`define BST_IDCODE_VAL  32'h1234_5001 // arbitrary identity value
`define BST_CELL_BITS   3
`define BST_CELL_OUT    2
`define BST_CELL_OE     1
`define BST_CELL_IN     0
`define BST_ST_RESET    16'h0001
`define BST_ST_IDLE     16'h0002
`define BST_ST_SEL_DR   16'h0004
`define BST_ST_CAP_DR   16'h0008
`define BST_ST_SH_DR    16'h0010
`define BST_ST_EX1_DR   16'h0020
`define BST_ST_PA_DR    16'h0040
`define BST_ST_EX2_DR   16'h0080
`define BST_ST_UPD_DR   16'h0100
`define BST_ST_SEL_IR   16'h0200
`define BST_ST_CAP_IR   16'h0400
`define BST_ST_SH_IR    16'h0800
`define BST_ST_EX1_IR   16'h1000
`define BST_ST_PA_IR    16'h2000
`define BST_ST_EX2_IR   16'h4000
`define BST_ST_UPD_IR   16'h8000
`endif

// file: bst_scan_cell.v
`timescale 1ns/100ps
`include "bst_regs.vh"
module bst_scan_cell (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       clk_en,
  input  wire       upd_en,
  input  wire       shift_sel,
  input  wire       test_mode,
  input  wire       cell_serial_in,
  input  wire       core_output_data,
  input  wire       core_output_enable,
  input  wire       pad_in,
  output wire       cell_serial_out,
  output reg        pad_out,
  output reg        pad_oe
);
  // capture chain order: out, oe, in; in-bit is last toward tdo
  reg [2:0] cap_r;
  reg       upd_out_r;
  reg       upd_oe_r;

  always @(posedge clock) begin
    if (!rst_n) begin
      cap_r <= 3'h0;
    end else if (clk_en) begin
      if (shift_sel) begin
        cap_r <= {cell_serial_in, cap_r[2:1]};
      end else begin
        cap_r <= {core_output_data, core_output_enable, pad_in};
      end
    end
  end

  assign cell_serial_out = cap_r[0];

  // no update register on the input path
  always @(posedge clock) begin
    if (!rst_n) begin
      upd_out_r <= 1'h0;
      upd_oe_r  <= 1'h0;
    end else if (upd_en) begin
      upd_out_r <= cap_r[`BST_CELL_OUT];
      upd_oe_r  <= cap_r[`BST_CELL_OE];
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      pad_out <= 1'h0;
      pad_oe  <= 1'h0;
    end else begin
      pad_out <= test_mode ? upd_out_r : core_output_data;
      pad_oe  <= test_mode ? upd_oe_r : core_output_enable;
    end
  end
endmodule

// file: bst_test_port_sva.sv
`timescale 1ns/100ps
module bst_test_port_sva #(parameter N_IO = 4) (
  input wire            clock,
  input wire            rst_n,
  input wire            tck,
  input wire            tms,
  input wire            tdi,
  input wire            tdo_o,
  input wire            tdo_oe,
  input wire [N_IO-1:0] core_output_data,
  input wire [N_IO-1:0] core_output_enable,
  input wire [N_IO-1:0] pad_in,
  input wire [N_IO-1:0] pad_out,
  input wire [N_IO-1:0] pad_oe,
  input wire            scan_active
);
  // counts raw tck rises with tms high; saturates so it never wraps
  reg       tck_d_r;
  reg [2:0] hi_r;
  always @(posedge clock) begin
    tck_d_r <= tck;
    if (!rst_n) hi_r <= 3'h0;
    else if (tck && !tck_d_r) hi_r <= !tms ? 3'h0 : hi_r + {2'h0, hi_r != 3'h7};
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_tdo_zero; !tdo_oe |-> !tdo_o; endproperty
  a_tdo_zero: assert property (p_tdo_zero) else $error("tdo set while off");
  property p_oe_low; $changed(tdo_oe) |-> !$past(tck) && !$past(tck, 2); endproperty
  a_oe_low: assert property (p_oe_low) else $error("tdo enable off fall");
  property p_tdo_low; $changed(tdo_o) |-> !$past(tck) && !$past(tck, 2); endproperty
  a_tdo_low: assert property (p_tdo_low) else $error("tdo moved off fall");
  property p_gap; $fell(tdo_oe) |-> !tdo_oe [*8]; endproperty
  a_gap: assert property (p_gap) else $error("shift state reentered fast");
  property p_state; $changed(scan_active) |-> $past(tck) || $past(tck, 2); endproperty
  a_state: assert property (p_state) else $error("mode moved off rise");
  property p_follow; $past(rst_n) && !scan_active && !$past(scan_active) && !$past(scan_active, 2)
    |-> pad_out == $past(core_output_data) && pad_oe == $past(core_output_enable); endproperty
  a_follow: assert property (p_follow) else $error("pads not functional");
  property p_tlr; hi_r > 3'h5 |-> !scan_active && !tdo_oe; endproperty
  a_tlr: assert property (p_tlr) else $error("reset state not reached");
  property p_tlr_pads; hi_r > 3'h5 |-> pad_out == $past(core_output_data); endproperty
  a_tlr_pads: assert property (p_tlr_pads) else $error("pads held in reset");
endmodule
bind bst_test_port bst_test_port_sva #(.N_IO(N_IO)) u_sva (.clock(clock), .rst_n(rst_n),
  .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
  .core_output_data(core_output_data), .core_output_enable(core_output_enable),
  .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .scan_active(scan_active));

// file: bst_jtag_host.sv
`timescale 1ns/100ps
module bst_jtag_host (
  output reg  tck,
  output reg  tms,
  output reg  tdi,
  input  wire tdo_o,
  input  wire tdo_oe
);
  reg  last_r;
  wire tdo_ln = tdo_oe ? tdo_o : ~last_r; // released pin must not look like stale data
  initial begin
    tck = 1'b0; // stands still low between frames
    tms = 1'b1;
    tdi = 1'b1;
    last_r = 1'b0;
  end
  always @(tdo_o or tdo_oe) if (tdo_oe) last_r = tdo_o;
  // 160 ns period; inputs settle a half period before the rise, held past it
  task step(input t, input di, output o);
    tms = t;
    tdi = di;
    #80 tck = 1'b1;
    #40 o = tdo_ln;
    #40 tck = 1'b0;
  endtask
  task walk(input [7:0] b, input integer n);
    integer i;
    reg o;
    for (i = 0; i < n; i = i + 1) step(b[i], 1'b1, o);
  endtask
  task scan(input [31:0] din, input integer n, output [31:0] dout);
    integer i;
    reg o;
    dout = 32'h0;
    for (i = 0; i < n; i = i + 1) begin
      step(i == n - 1, din[i], o); // last bit goes with the exit
      dout[i] = o;
    end
  endtask
  task ir(input [9:0] code, output [31:0] cap);
    walk(8'h06, 5);
    scan({22'h0, code}, 10, cap);
    walk(8'h01, 2);
  endtask
  task dr(input [31:0] din, input integer n, output [31:0] dout);
    walk(8'h02, 4);
    scan(din, n, dout);
    walk(8'h01, 2);
  endtask
  task tlr;
    walk(8'h3F, 6);
  endtask
endmodule

// file: boundary_scan_test_port_test.sv
`timescale 1ns/100ps
`include "bst_regs.vh"
module boundary_scan_test_port_test;
  localparam [11:0] PRE = 12'h9B6;
  reg        clock;
  reg        rst_n;
  reg  [3:0] cod;
  reg  [3:0] coe;
  reg  [3:0] pin;
  wire       tck, tms, tdi, tdo_o, tdo_oe, scan_active;
  wire [3:0] pad_out, pad_oe;
  integer    n_mismatch = 0;
  integer    n_tests = 0;
  integer    i;
  reg [31:0] d, e;
  bst_test_port DUT (.clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe), .core_output_data(cod), .core_output_enable(coe),
    .pad_in(pin), .pad_out(pad_out), .pad_oe(pad_oe), .scan_active(scan_active));
  bst_jtag_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task chk(input string what, input [31:0] seen, input [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_of_test;
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task t_ir_bypass;
    host.ir(`BST_OP_BYPASS, d);
    chk("ir capture", d, 32'h1);
    chk("tdo idle", {31'h0, tdo_oe}, 32'h0);
    host.dr(32'hA5, 8, d);
    chk("bypass", d, 32'h4A);
    host.ir(`BST_OP_CLAMP, d);
    host.dr(32'h3C, 8, d);
    chk("clamp as bypass", d, 32'h78);
  endtask
  task t_idcode;
    host.tlr;
    host.dr(32'h0, 32, d);
    chk("idcode", d, `BST_IDCODE_VAL);
  endtask
  task t_sample;
    @(posedge clock) #1;
    cod = 4'h5;
    coe = 4'h3;
    pin = 4'hC;
    host.ir(`BST_OP_SAMPLE, d);
    host.dr({20'h0, PRE}, 12, d);
    e = 32'h0;
    for (i = 0; i < 4; i = i + 1) e[3*i+:3] = {cod[i], coe[i], pin[i]};
    chk("chain", d, e);
    chk("sample pads", {pad_out, pad_oe, 23'h0, scan_active}, {cod, coe, 24'h0});
  endtask
  task t_extest;
    host.ir(`BST_OP_EXTEST, d);
    e = 32'h1;
    for (i = 0; i < 4; i = i + 1) {e[28+i], e[24+i]} = {PRE[3*i+2], PRE[3*i+1]};
    chk("test pads", {pad_out, pad_oe, 23'h0, scan_active}, e);
    host.tlr;
    repeat (4) @(posedge clock);
    #1;
    chk("pads freed", {pad_out, pad_oe, 23'h0, scan_active}, {cod, coe, 24'h0});
  endtask
  initial begin
    rst_n = 1'h0;
    cod = 4'h0;
    coe = 4'h0;
    pin = 4'h0;
    repeat (4) @(posedge clock);
    #1 rst_n = 1'h1;
    repeat (4) @(posedge clock);
    #1;
    t_ir_bypass;
    t_idcode;
    t_sample;
    t_extest;
    end_of_test;
  end
  initial begin
    #1000000 n_mismatch = n_mismatch + 1;
    end_of_test;
  end
endmodule
